/* File: design/ccr_params.svh */
// constants for the charger control register pair
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_IDX_CTRL 8'h01
`define CCR_IDX_CURR 8'h02
`define CCR_RST_CTRL 8'h1A
`define CCR_RST_CURR 8'hA2
`define CCR_BIT_LLM_OFF 7
`define CCR_BIT_WD_STROBE 6
`define CCR_BIT_BOOST_EN 5
`define CCR_BIT_CHG_EN 4
`define CCR_SYSMIN_MSB 3
`define CCR_SYSMIN_LSB 1
`define CCR_BIT_LOWBAT_SEL 0
`define CCR_BIT_BOOST_CURRENT_LIMIT_SELECT 7
`define CCR_BIT_SW_FULL_ON 6
`define CCR_FAST_CHARGE_CURRENT_CODE_MSB 5
`define CCR_FAST_CHARGE_CURRENT_CODE_LSB 0
`define CCR_WD_MASK_CTRL 8'h70
`define CCR_WD_MASK_CURR 8'hBF
`define CCR_ILIM_700_MA 12'd700
`define CCR_SLAVE_ADDR 7'h6B
`endif

/* File: design/ccr_pkg.sv */
// types for the charger control register pair
package ccr_pkg;
   typedef logic [7:0] ccr_byte_t;
   typedef logic [7:0] ccr_index_t;
   typedef logic [11:0] ccr_ma_t;
endpackage : ccr_pkg

/* File: design/ccr_reg_cell.sv */
// one 8-bit control register with power-on, command and watchdog reset
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_reg_cell #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WD_MASK = 8'h00
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reg_reset,
   input wire logic wd_expired,
   input wire logic wr_en,
   input wire ccr_pkg::ccr_byte_t wr_data,
   output ccr_pkg::ccr_byte_t value
);
   import ccr_pkg::*;
   ccr_byte_t value_q;
   assign value = value_q;
   // [R15] reset sources
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         value_q <= RESET_VAL;
      end else if (reg_reset) begin
         value_q <= RESET_VAL;
      end else if (wr_en) begin
         value_q <= wr_data;
      end else if (wd_expired) begin
         value_q <= (value_q & ~WD_MASK) | (RESET_VAL & WD_MASK);
      end
   end
endmodule : ccr_reg_cell

/* File: design/ccr_ctrl_regs.sv */
// charger control register pair behind the serial slave port
`timescale 1ns/100ps
`include "ccr_params.svh"
// Operation
// [R1] control register at index 0x01, power-on value 0x1A
// [R2] current register at index 0x02, power-on value 0xA2
// [R3] bit 7 of first register forbids light-load pulse mode
// [R4] host writes strobe 1 to restart watchdog before expiry
// [R5] strobe bit reads back 0 after watchdog restart
// [R6] boost enable overrides charge enable
// [R7] charging needs charge bit 1 and charge pin low
// [R8] bits 3:1 hold minimum system voltage code, default 101
// [R9] bit 0 selects boost low battery threshold
// [R10] bit 7 of second register selects boost current limit
// [R11] switch full on, or high resistance below 700 mA limit
// [R12] input switch off while boost is active
// [R13] bits 5:0 hold charge current code, 60 mA per step
// [R14] zero charge current code disables charging
// [R15] reset command clears all; watchdog clears selected fields
// [R16] slave address 0x6B, registers eight bits wide
// [R17] index advances after every data byte
module ccr_ctrl_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic charge_enable_pin_n,
   input wire logic reg_reset,
   input wire logic wd_expired,
   input wire logic [6:0] dev_addr,
   input wire logic addr_wr,
   input wire ccr_pkg::ccr_index_t addr_index,
   input wire logic data_wr,
   input wire ccr_pkg::ccr_byte_t data_wr_byte,
   input wire logic data_rd,
   input wire ccr_pkg::ccr_ma_t input_current_limit,
   output logic addr_match,
   output logic index_valid,
   output ccr_pkg::ccr_byte_t rd_data,
   output ccr_pkg::ccr_index_t cur_index,
   output logic wd_restart,
   output logic light_load_mode_off,
   output logic boost_output_enable,
   output logic charge_active,
   output logic [2:0] min_system_voltage_code,
   output logic boost_low_battery_select,
   output logic boost_current_limit_select,
   output logic input_switch_on,
   output logic input_switch_full_on,
   output logic [5:0] fast_charge_current_code,
   output ccr_pkg::ccr_ma_t fast_charge_current_ma
);
   import ccr_pkg::*;
   ccr_byte_t ctrl_val;
   ccr_byte_t curr_val;
   ccr_byte_t ctrl_wr_data;
   ccr_index_t index_q;
   ccr_byte_t rd_data_q;
   logic pin_sync1_q;
   logic pin_sync2_q;
   logic wd_restart_q;
   logic wr_ctrl;
   logic wr_curr;
   logic chg_bit;

   // [R16] slave address compare
   assign addr_match = (dev_addr == `CCR_SLAVE_ADDR);
   assign index_valid = (index_q == `CCR_IDX_CTRL) ||
      (index_q == `CCR_IDX_CURR);
   assign cur_index = index_q;
   assign rd_data = rd_data_q;
   assign wd_restart = wd_restart_q;

   // [R1] first register decode
   assign wr_ctrl = data_wr && (index_q == `CCR_IDX_CTRL);
   // [R2] second register decode
   assign wr_curr = data_wr && (index_q == `CCR_IDX_CURR);
   // [R5] strobe never stored
   assign ctrl_wr_data = data_wr_byte & ~(8'h01 << `CCR_BIT_WD_STROBE);

   ccr_reg_cell #(
      .RESET_VAL(`CCR_RST_CTRL),
      .WD_MASK(`CCR_WD_MASK_CTRL)
   ) u_ctrl (
      .core_clk(core_clk),
      .rst(rst),
      .reg_reset(reg_reset),
      .wd_expired(wd_expired),
      .wr_en(wr_ctrl),
      .wr_data(ctrl_wr_data),
      .value(ctrl_val)
   );

   ccr_reg_cell #(
      .RESET_VAL(`CCR_RST_CURR),
      .WD_MASK(`CCR_WD_MASK_CURR)
   ) u_curr (
      .core_clk(core_clk),
      .rst(rst),
      .reg_reset(reg_reset),
      .wd_expired(wd_expired),
      .wr_en(wr_curr),
      .wr_data(data_wr_byte),
      .value(curr_val)
   );

   // [R17] index load and advance
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         index_q <= 8'h00;
      end else if (addr_wr) begin
         index_q <= addr_index;
      end else if (data_wr || data_rd) begin
         index_q <= index_q + 8'h01;
      end
   end

   // read data captured from the current index
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_data_q <= 8'h00;
      end else begin
         case (index_q)
            `CCR_IDX_CTRL: rd_data_q <= ctrl_val;
            `CCR_IDX_CURR: rd_data_q <= curr_val;
            default: rd_data_q <= 8'h00;
         endcase
      end
   end

   // [R4] restart pulse to watchdog
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wd_restart_q <= 1'b0;
      end else begin
         wd_restart_q <= wr_ctrl && data_wr_byte[`CCR_BIT_WD_STROBE];
      end
   end

   // charge pin synchroniser
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_sync1_q <= 1'b1;
         pin_sync2_q <= 1'b1;
      end else begin
         pin_sync1_q <= charge_enable_pin_n;
         pin_sync2_q <= pin_sync1_q;
      end
   end

   // [R3] light load mode
   assign light_load_mode_off = ctrl_val[`CCR_BIT_LLM_OFF];
   assign boost_output_enable = ctrl_val[`CCR_BIT_BOOST_EN];
   assign chg_bit = ctrl_val[`CCR_BIT_CHG_EN];
   // [R8] system voltage code
   assign min_system_voltage_code =
      ctrl_val[`CCR_SYSMIN_MSB:`CCR_SYSMIN_LSB];
   // [R9] low battery select
   assign boost_low_battery_select = ctrl_val[`CCR_BIT_LOWBAT_SEL];
   // [R10] boost limit select
   assign boost_current_limit_select = curr_val[`CCR_BIT_BOOST_CURRENT_LIMIT_SELECT];
   // [R13] charge current code
   assign fast_charge_current_code = curr_val[`CCR_FAST_CHARGE_CURRENT_CODE_MSB:`CCR_FAST_CHARGE_CURRENT_CODE_LSB];
   assign fast_charge_current_ma =
      12'(fast_charge_current_code) * 12'd60;

   // [R6] [R7] [R14] charge gating
   assign charge_active = chg_bit && !pin_sync2_q &&
      !boost_output_enable && (fast_charge_current_code != 6'h00);

   // [R11] [R12] input switch
   assign input_switch_on = !boost_output_enable;
   assign input_switch_full_on = !boost_output_enable &&
      (curr_val[`CCR_BIT_SW_FULL_ON] ||
       (input_current_limit >= `CCR_ILIM_700_MA));

   // [R1] power-on value
   property p_ctrl_por;
      @(posedge core_clk) $fell(rst) |-> ctrl_val == `CCR_RST_CTRL;
   endproperty
   a_ctrl_por: assert property (p_ctrl_por) else $error("ctrl por"); // [R1]
   // [R2] power-on value
   property p_curr_por;
      @(posedge core_clk) $fell(rst) |-> curr_val == `CCR_RST_CURR;
   endproperty
   a_curr_por: assert property (p_curr_por) else $error("curr por"); // [R2]
   // [R5] strobe reads zero
   property p_strobe_zero;
      @(posedge core_clk) disable iff (rst) !ctrl_val[`CCR_BIT_WD_STROBE];
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) else $error("strb"); // [R5]
   // [R4] restart pulse follows write
   sequence s_strobe_wr;
      wr_ctrl && data_wr_byte[`CCR_BIT_WD_STROBE];
   endsequence
   property p_restart;
      @(posedge core_clk) disable iff (rst)
         s_strobe_wr |=> wd_restart;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart"); // [R4]
   // [R6] boost blocks charge
   property p_boost_prio;
      @(posedge core_clk) disable iff (rst)
         boost_output_enable |-> !charge_active;
   endproperty
   a_boost_prio: assert property (p_boost_prio) else $error("boost"); // [R6]
   // [R14] zero code blocks charge
   property p_zero_code;
      @(posedge core_clk) disable iff (rst)
         fast_charge_current_code == 6'h00 |-> !charge_active;
   endproperty
   a_zero_code: assert property (p_zero_code) else $error("zero"); // [R14]
   // [R12] switch off in boost
   property p_sw_off;
      @(posedge core_clk) disable iff (rst)
         boost_output_enable |-> !input_switch_on && !input_switch_full_on;
   endproperty
   a_sw_off: assert property (p_sw_off) else $error("switch on"); // [R12]
   // [R17] index advances
   property p_index_adv;
      @(posedge core_clk) disable iff (rst)
         !addr_wr && data_wr |=> cur_index == $past(cur_index) + 8'h01;
   endproperty
   a_index_adv: assert property (p_index_adv) else $error("index"); // [R17]
   // [R15] watchdog keeps sys code
   property p_wd_keep;
      @(posedge core_clk) disable iff (rst)
         wd_expired && !reg_reset && !data_wr |=>
         $stable(min_system_voltage_code) && chg_bit;
   endproperty
   a_wd_keep: assert property (p_wd_keep) else $error("wd reset"); // [R15]
endmodule : ccr_ctrl_regs

/* File: dv/ccr_host_model.sv */
// host side model driving index, write and read strobes
`timescale 1ns/100ps
module ccr_host_model (
   input wire logic core_clk,
   output logic [6:0] dev_addr,
   output logic addr_wr,
   output ccr_pkg::ccr_index_t addr_index,
   output logic data_wr,
   output ccr_pkg::ccr_byte_t data_wr_byte,
   output logic data_rd
);
   import ccr_pkg::*;
   initial begin
      dev_addr = 7'h6B;
      addr_wr = 1'b0;
      addr_index = 8'h00;
      data_wr = 1'b0;
      data_wr_byte = 8'h00;
      data_rd = 1'b0;
   end
   task automatic idx(input ccr_index_t i);
      @(posedge core_clk);
      addr_wr <= 1'b1;
      addr_index <= i;
      @(posedge core_clk);
      addr_wr <= 1'b0;
   endtask : idx
   // index then back to back bytes
   task automatic wr(input ccr_index_t i, input ccr_byte_t b0, b1,
      input int n);
      @(posedge core_clk);
      addr_wr <= 1'b1;
      addr_index <= i;
      for (int k = 0; k < n; k++) begin
         @(posedge core_clk);
         addr_wr <= 1'b0;
         data_wr <= 1'b1;
         data_wr_byte <= (k == 0) ? b0 : b1;
      end
      @(posedge core_clk);
      data_wr <= 1'b0;
      data_wr_byte <= ~data_wr_byte;
   endtask : wr
   task automatic adv;
      @(posedge core_clk);
      data_rd <= 1'b1;
      @(posedge core_clk);
      data_rd <= 1'b0;
   endtask : adv
endmodule : ccr_host_model

/* File: dv/tb_top.sv */
// testbench for the charger control register pair
`timescale 1ns/100ps
`include "ccr_params.svh"
module tb_top;
   import ccr_pkg::*;
   logic core_clk, rst, charge_enable_pin_n, reg_reset, wd_expired;
   logic [6:0] dev_addr;
   logic addr_wr, data_wr, data_rd, addr_match, index_valid, wd_restart;
   ccr_index_t addr_index, cur_index;
   ccr_byte_t data_wr_byte, rd_data;
   ccr_ma_t input_current_limit, fast_charge_current_ma;
   logic light_load_mode_off, boost_output_enable, charge_active;
   logic boost_low_battery_select, boost_current_limit_select;
   logic input_switch_on, input_switch_full_on;
   logic [2:0] min_system_voltage_code;
   logic [5:0] fast_charge_current_code;
   int fails = 0;
   int checks = 0;
   int wdp = 0;
   ccr_host_model i_ccr_host_model (.core_clk, .dev_addr, .addr_wr,
      .addr_index, .data_wr, .data_wr_byte, .data_rd);
   ccr_ctrl_regs i_ccr_ctrl_regs (.core_clk, .rst, .charge_enable_pin_n,
      .reg_reset, .wd_expired, .dev_addr, .addr_wr, .addr_index, .data_wr,
      .data_wr_byte, .data_rd, .input_current_limit, .addr_match,
      .index_valid, .rd_data, .cur_index, .wd_restart, .light_load_mode_off,
      .boost_output_enable, .charge_active, .min_system_voltage_code,
      .boost_low_battery_select, .boost_current_limit_select,
      .input_switch_on, .input_switch_full_on, .fast_charge_current_code,
      .fast_charge_current_ma);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (wd_restart === 1'b1) wdp++;
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [11:0] got, exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask : cmp
   task automatic get(input ccr_index_t i, input ccr_byte_t e0, e1);
      i_ccr_host_model.idx(i);
      @(posedge core_clk);
      #1 cmp(rd_data, e0);
      i_ccr_host_model.adv();
      @(posedge core_clk);
      #1 cmp(rd_data, e1);
   endtask : get
   task automatic cmd(input bit w);
      @(posedge core_clk);
      wd_expired <= w;
      reg_reset <= !w;
      @(posedge core_clk);
      wd_expired <= 1'b0;
      reg_reset <= 1'b0;
   endtask : cmd
   task automatic settle;
      repeat (4) @(posedge core_clk);
      #1;
   endtask : settle
   initial begin
      #20000;
      fails++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      charge_enable_pin_n = 1'b1;
      reg_reset = 1'b0;
      wd_expired = 1'b0;
      input_current_limit = 12'd699;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      get(`CCR_IDX_CTRL, `CCR_RST_CTRL, `CCR_RST_CURR);
      cmp(index_valid, 1'b1);
      cmp(addr_match, 1'b1);
      cmp(min_system_voltage_code, 3'h5);
      cmp(fast_charge_current_ma, 12'd2040);
      cmp(boost_current_limit_select, 1'b1);
      cmp(charge_active, 1'b0);
      @(posedge core_clk) charge_enable_pin_n <= 1'b0;
      settle();
      cmp(charge_active, 1'b1);
      i_ccr_host_model.wr(8'h01, 8'h50, 8'h00, 2);
      settle();
      cmp(wdp, 1);
      cmp(charge_active, 1'b0);
      get(8'h01, 8'h10, 8'h00);
      i_ccr_host_model.wr(8'h02, 8'h7F, 8'h00, 1);
      i_ccr_host_model.wr(8'h01, 8'hB1, 8'h00, 1);
      settle();
      cmp(fast_charge_current_ma, 12'd3780);
      cmp(fast_charge_current_code, 6'h3F);
      cmp(boost_current_limit_select, 1'b0);
      cmp(boost_output_enable, 1'b1);
      cmp(charge_active, 1'b0);
      cmp(input_switch_on, 1'b0);
      cmp(input_switch_full_on, 1'b0);
      cmp(light_load_mode_off, 1'b1);
      cmp(boost_low_battery_select, 1'b1);
      cmp(min_system_voltage_code, 3'h0);
      cmd(1'b1);
      get(8'h01, 8'h91, 8'hE2);
      cmp(wdp, 1);
      cmp(input_switch_on, 1'b1);
      cmp(input_switch_full_on, 1'b1);
      i_ccr_host_model.wr(8'h02, 8'hA2, 8'h00, 1);
      settle();
      cmp(input_switch_full_on, 1'b0);
      @(posedge core_clk) input_current_limit <= 12'd700;
      settle();
      cmp(input_switch_full_on, 1'b1);
      cmd(1'b0);
      get(8'h01, `CCR_RST_CTRL, `CCR_RST_CURR);
      i_ccr_host_model.wr(8'h00, 8'hFF, 8'h3B, 2);
      get(8'h01, 8'h3B, `CCR_RST_CURR);
      @(posedge core_clk) rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      get(8'h01, `CCR_RST_CTRL, `CCR_RST_CURR);
      i_ccr_host_model.idx(8'h05);
      #1 cmp(index_valid, 1'b0);
      cmp(cur_index, 8'h05);
      end_of_test();
   end
endmodule : tb_top
